// ---- verilog/gpg_port.sv ----
// gpio port g: five bidirectional pins, one input-only pin, apb registers.
// assumes an apb master on clk, pads resolved by the surroundings from
// pad_out and pad_oe, and peripherals on the same clock as this block.
//
// Function
// (R1) six pins: five bidirectional at bits 0..4, one input-only at bit 5
// (R2) direction bit 1 makes the pin an input, driver released
// (R3) direction bit 0 drives the output latch onto the pin
// (R4) output latch is memory mapped; reads return latch, not pin
// (R5) an enabled peripheral forces pin direction regardless of direction bit
// (R6) peripheral override never lands in the direction register
// (R7) every reset returns the direction register to all ones
// (R8) master clear enable set (default) makes pin 5 the master clear
// (R9) master clear enable clear makes pin 5 a plain input-only pin
// (R10) pin value bit 5 shows pin 5 only without master clear; 7:6 zero
// (R11) latch kept across master clear; defined only by power-on reset
// (R12) pin 1 shared with serial two transmit/clock, pin 2 with receive/data
// (R13) pins 0, 3, 4 shared with capture/pwm channels three, four, five
// (R14) pin value reads sampled pins; writes go to the output latch
`timescale 1ns/1ps
module gpg_port #(
   parameter int IO_PINS = gpg_pkg::GPG_IO_PINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic [gpg_pkg::GPG_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpg_pkg::GPG_DATA_W-1:0] pwdata,
   input wire logic [gpg_pkg::GPG_STRB_W-1:0] pstrb,
   output logic [gpg_pkg::GPG_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // pads
   input wire logic [gpg_pkg::GPG_PAD_W-1:0] pad_in,
   output logic [IO_PINS-1:0] pad_out,
   output logic [IO_PINS-1:0] pad_oe,
   // peripheral sharing
   input wire logic [IO_PINS-1:0] periph_enable,
   input wire logic [IO_PINS-1:0] periph_force_out,
   input wire logic [IO_PINS-1:0] periph_data_out,
   output logic [gpg_pkg::GPG_PAD_W-1:0] periph_data_in,
   // device reset request from pin 5
   output logic master_clear_reset
);
   import gpg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // elaboration check

   generate
      if (IO_PINS < 1 || IO_PINS > GPG_ONLY_BIT) begin : g_bad_width
         $error("gpg_port: IO_PINS must lie in 1..5");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      logic [IO_PINS-1:0] latch;
      logic [IO_PINS-1:0] dir;
      logic mce;
      logic master_clear_input;
      logic [IO_PINS-1:0] pout;
      logic [IO_PINS-1:0] poe;
      logic ready;
      logic slverr;
      logic [GPG_DATA_W-1:0] rdata;
   } gpg_regs_t;

   gpg_regs_t r;
   gpg_regs_t next_r;

   ////////////////////////////////////////////////////////////////////////////////
   // pad synchroniser

   gpg_sync_if #(.W(GPG_PAD_W)) pin_sif ();

   assign pin_sif.raw = pad_in;

   gpg_sync #(
      .W(GPG_PAD_W)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .sif(pin_sif.sync)
   );

   logic [GPG_PAD_W-1:0] pin_lvl;

   assign pin_lvl = pin_sif.synced;

   ////////////////////////////////////////////////////////////////////////////////
   // per-pin drive selection

   logic [IO_PINS-1:0] drv_oe;
   logic [IO_PINS-1:0] drv_val;

   // pin 0, 3, 4 carry the capture/pwm channels, pins 1, 2 the serial port;
   // which one is enabled is the peripheral's business, not ours
   generate
      for (genvar i = 0; i < IO_PINS; i++) begin : g_pin
         // an enabled peripheral decides direction on its own
         assign drv_oe[i] = periph_enable[i] ? periph_force_out[i] : ~r.dir[i]; // R5
         // forced input by a peripheral leaves the driver off
         assign drv_val[i] = (periph_enable[i] & periph_force_out[i])
            ? periph_data_out[i] : r.latch[i]; // R3
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode

   logic setup_phase;
   logic write_take;
   logic addr_mapped;
   logic low_lane;
   logic [GPG_REG_W-1:0] rd_byte;
   logic [GPG_REG_W-1:0] wr_byte;

   // answer is prepared in the setup cycle so pready can come from a flop
   assign setup_phase = psel & ~penable & ~r.ready;
   assign write_take = psel & penable & r.ready & pwrite & ~r.slverr;
   assign low_lane = pstrb[GPG_LOW_LANE];
   assign wr_byte = pwdata[GPG_REG_W-1:0];

   always_comb begin
      case (paddr)
         GPG_OFS_PIN_VALUE: addr_mapped = 1'b1;
         GPG_OFS_OUTPUT_LATCH: addr_mapped = 1'b1;
         GPG_OFS_DIRECTION: addr_mapped = 1'b1;
         GPG_OFS_CONFIG: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux

   always_comb begin
      rd_byte = '0;
      case (paddr)
         GPG_OFS_PIN_VALUE: begin
            // sampled pin levels, never the latch
            rd_byte[IO_PINS-1:0] = pin_lvl[IO_PINS-1:0]; // R14
            // pin 5 is hidden while it serves as master clear
            rd_byte[GPG_ONLY_BIT] = pin_lvl[GPG_ONLY_BIT] & ~r.mce; // R10
         end
         GPG_OFS_OUTPUT_LATCH: begin
            rd_byte[IO_PINS-1:0] = r.latch; // R4
         end
         GPG_OFS_DIRECTION: begin
            // software value only; overrides live in drv_oe
            rd_byte[IO_PINS-1:0] = r.dir; // R6
         end
         GPG_OFS_CONFIG: begin
            rd_byte[GPG_MCE_BIT] = r.mce;
            rd_byte[GPG_MASTER_CLEAR_INPUT_STAT_BIT] = r.master_clear_input;
         end
         default: begin
            rd_byte = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      next_r = r;

      // bus answer: one access cycle, no wait states
      next_r.ready = setup_phase;
      next_r.slverr = setup_phase & ~addr_mapped;
      next_r.rdata = '0;
      if (setup_phase && !pwrite && addr_mapped) begin
         next_r.rdata = GPG_DATA_W'(rd_byte);
      end

      // register writes, low byte lane only
      if (write_take && low_lane) begin
         case (paddr)
            GPG_OFS_PIN_VALUE: begin
               // same effect as a latch write
               next_r.latch = wr_byte[IO_PINS-1:0]; // R14
            end
            GPG_OFS_OUTPUT_LATCH: begin
               next_r.latch = wr_byte[IO_PINS-1:0]; // R4
            end
            GPG_OFS_DIRECTION: begin
               next_r.dir = wr_byte[IO_PINS-1:0];
            end
            GPG_OFS_CONFIG: begin
               next_r.mce = wr_byte[GPG_MCE_BIT];
            end
            default: begin
               next_r.latch = r.latch;
            end
         endcase
      end

      // pin 5 low with master clear enabled resets the device
      next_r.master_clear_input = r.mce & ~pin_lvl[GPG_ONLY_BIT]; // R8
      // without master clear pin 5 is only read, never reset source
      if (!r.mce) begin
         next_r.master_clear_input = 1'b0; // R9
      end

      // master clear is an other-reset: direction back to inputs,
      // latch untouched; it wins over a direction write in flight
      if (r.master_clear_input) begin
         next_r.dir = GPG_DIR_RESET[IO_PINS-1:0]; // R7
         next_r.latch = r.latch; // R11
      end

      // pad drivers; one cycle behind the registers by design,
      // so every pad output comes from a flop
      next_r.poe = drv_oe; // R2
      next_r.pout = drv_val; // R3
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // power-on: latch is undefined on silicon, cleared here for a
         // deterministic start
         r.latch <= GPG_LATCH_RESET[IO_PINS-1:0]; // R11
         r.dir <= GPG_DIR_RESET[IO_PINS-1:0]; // R7
         r.mce <= GPG_MCE_RESET; // R8
         r.master_clear_input <= 1'b0;
         r.pout <= '0;
         r.poe <= '0;
         r.ready <= 1'b0;
         r.slverr <= 1'b0;
         r.rdata <= '0;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   // only bits 0..4 have drivers; pin 5 has no latch or direction
   assign pad_out = r.pout; // R1
   assign pad_oe = r.poe; // R2
   assign prdata = r.rdata;
   assign pready = r.ready;
   assign pslverr = r.slverr;
   // peripherals see the synchronised levels of all six pins
   assign periph_data_in = pin_lvl; // R12 R13
   assign master_clear_reset = r.master_clear_input;

endmodule : gpg_port

// ---- verilog/gpg_pkg.sv ----
// gpio port g constants: register map, field positions, reset values.
// assumes a 32-bit apb master and a 200 mhz system clock.
package gpg_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // port shape
   localparam int GPG_IO_PINS = 5;
   localparam int GPG_ONLY_BIT = 5;
   localparam int GPG_PAD_W = GPG_ONLY_BIT + 1;
   localparam int GPG_REG_W = 8;
   localparam int GPG_SYNC_STAGES = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // apb map
   localparam int GPG_ADDR_W = 12;
   localparam int GPG_DATA_W = 32;
   localparam int GPG_STRB_W = 4;
   localparam logic [11:0] GPG_OFS_PIN_VALUE = 12'h000;
   localparam logic [11:0] GPG_OFS_OUTPUT_LATCH = 12'h004;
   localparam logic [11:0] GPG_OFS_DIRECTION = 12'h008;
   localparam logic [11:0] GPG_OFS_CONFIG = 12'h00c;

   ////////////////////////////////////////////////////////////////////////////////
   // fields and reset values
   localparam int GPG_MCE_BIT = 7;
   localparam int GPG_MASTER_CLEAR_INPUT_STAT_BIT = 0;
   localparam int GPG_LOW_LANE = 0;
   localparam logic GPG_MCE_RESET = 1'b1;
   localparam logic [7:0] GPG_DIR_RESET = 8'h1f;
   localparam logic [7:0] GPG_LATCH_RESET = 8'h00;

endpackage : gpg_pkg

// ---- verilog/gpg_sync_if.sv ----
// carrier between the port and its pad synchroniser.
// assumes raw levels arrive asynchronously from the pads.
`timescale 1ns/1ps
interface gpg_sync_if #(parameter int W = 6);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface : gpg_sync_if

// ---- verilog/gpg_sync.sv ----
// two-flop synchroniser for the pad input levels.
// assumes clk is the system clock; raw comes from another domain.
`timescale 1ns/1ps
module gpg_sync #(
   parameter int W = 6
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // levels
   gpg_sync_if.sync sif
);
   import gpg_pkg::*;

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } gpg_sync_t;

   gpg_sync_t r;
   gpg_sync_t next_r;

   // stage1 is read only by stage2; nothing else may look at it
   always_comb begin
      next_r = r;
      next_r.stage1 = sif.raw;
      next_r.stage2 = r.stage1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sif.synced = r.stage2;

endmodule : gpg_sync

// ---- sim/gpg_port_checker.sv ----
// checker for gpg_port: apb answer, pad override, sync path, master clear.
// assumes it is bound to gpg_port and sees its ports only.
`timescale 1ns/1ps
module gpg_port_checker #(
   parameter int IO_PINS = gpg_pkg::GPG_IO_PINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb
   input wire logic [gpg_pkg::GPG_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic [gpg_pkg::GPG_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pads and peripherals
   input wire logic [gpg_pkg::GPG_PAD_W-1:0] pad_in,
   input wire logic [IO_PINS-1:0] pad_out,
   input wire logic [IO_PINS-1:0] pad_oe,
   input wire logic [IO_PINS-1:0] periph_enable,
   input wire logic [IO_PINS-1:0] periph_force_out,
   input wire logic [IO_PINS-1:0] periph_data_out,
   input wire logic [gpg_pkg::GPG_PAD_W-1:0] periph_data_in,
   input wire logic master_clear_reset
);
   import gpg_pkg::*;
   // synchroniser holds stale levels for two edges after reset
   logic [1:0] since;
   always_ff @(posedge clk) begin
      if (sys_rst) since <= 2'h0;
      else if (since != 2'h3) since <= since + 2'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   ack_timing_a: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   err_map_a: assert property (psel && !penable && paddr > GPG_OFS_CONFIG |=> pslverr)
      else $error("unmapped address not refused");
   err_qual_a: assert property (pslverr |-> pready && $past(psel))
      else $error("error without answer");
   idle_data_a: assert property (!pready |-> prdata == '0)
      else $error("read data outside answer");
   upper_zero_a: assert property (pready |-> prdata[31:8] == '0)
      else $error("upper read bits set");
   force_dir_a: assert property (1'b1 |=> (pad_oe & $past(periph_enable))
      == $past(periph_enable & periph_force_out))
      else $error("peripheral direction ignored");
   force_data_a: assert property (1'b1 |=> (pad_out & pad_oe & $past(periph_enable))
      == $past(periph_enable & periph_force_out & periph_data_out))
      else $error("peripheral data not driven");
   sync_path_a: assert property (since == 2'h3 |-> periph_data_in == $past(pad_in, 2))
      else $error("pad level not passed on");
   clear_cause_a: assert property (master_clear_reset |-> !$past(periph_data_in[5]))
      else $error("master clear without low pin");
endmodule : gpg_port_checker
bind gpg_port gpg_port_checker #(.IO_PINS(IO_PINS)) chk_i (.clk(clk), .sys_rst(sys_rst),
   .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .periph_enable(periph_enable), .periph_force_out(periph_force_out),
   .periph_data_out(periph_data_out), .periph_data_in(periph_data_in),
   .master_clear_reset(master_clear_reset));

// ---- sim/gpg_pads.sv ----
// board model: resolves each pad from block drive and board level.
// assumes board drives are weak pulls, so the block always wins.
`timescale 1ns/1ps
module gpg_pads #(
   parameter int IO_PINS = gpg_pkg::GPG_IO_PINS
) (
   // block side
   input wire logic [IO_PINS-1:0] pad_out,
   input wire logic [IO_PINS-1:0] pad_oe,
   // board side
   input wire logic [gpg_pkg::GPG_PAD_W-1:0] ext_level,
   output logic [gpg_pkg::GPG_PAD_W-1:0] pad_in
);
   always_comb begin
      pad_in = ext_level;
      for (int i = 0; i < IO_PINS; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
      end
   end
endmodule : gpg_pads

// ---- sim/tb_six_pin_gpio_port_with_reset_pin.sv ----
// bench for gpg_port: apb tasks, pad and peripheral scenarios.
// assumes gpg_pads closes the pad loop and the checker is bound.
`timescale 1ns/1ps
module tb_six_pin_gpio_port_with_reset_pin;
   import gpg_pkg::*;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, mcr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [4:0] pad_out, pad_oe, p_en, p_fo, p_do;
   logic [5:0] pad_in, pdi, ext;
   logic [7:0] rd;
   int err_total, checks_done;
   gpg_port dut (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .periph_enable(p_en), .periph_force_out(p_fo),
      .periph_data_out(p_do), .periph_data_in(pdi), .master_clear_reset(mcr));
   gpg_pads pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext), .pad_in(pad_in));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic give_verdict;
      if (err_total == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // request held until pready is sampled high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
         input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      // no answer time assumed; a hang is ended by the watchdog
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] exp);
      xfer(1'b0, a, 8'h00, 4'hf);
      chk(nm, exp, rd);
   endtask : rdchk
   // pads lag one edge, synced pin levels two more
   task automatic wt;
      repeat (6) @(posedge clk);
      #1;
   endtask : wt
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      give_verdict;
   end
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      sys_rst = 1'b1;
      {p_en, p_fo, p_do} = '0;
      ext = 6'h28;
      err_total = 0;
      checks_done = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      wt;
      chk("oe", 8'h00, {3'h0, pad_oe});
      chk("pdi", 8'h28, {2'h0, pdi});
      rdchk("dir", GPG_OFS_DIRECTION, GPG_DIR_RESET);
      rdchk("lat", GPG_OFS_OUTPUT_LATCH, GPG_LATCH_RESET);
      rdchk("cfg", GPG_OFS_CONFIG, 8'h80);
      rdchk("pin", GPG_OFS_PIN_VALUE, 8'h08);
      xfer(1'b1, GPG_OFS_OUTPUT_LATCH, 8'h15, 4'h1);
      xfer(1'b1, GPG_OFS_DIRECTION, 8'h0a, 4'h1);
      wt;
      chk("oe", 8'h15, {3'h0, pad_oe});
      chk("out", 8'h15, {3'h0, pad_out & pad_oe});
      chk("pdi", 8'h3d, {2'h0, pdi});
      rdchk("pin", GPG_OFS_PIN_VALUE, 8'h1d);
      rdchk("lat", GPG_OFS_OUTPUT_LATCH, 8'h15);
      xfer(1'b1, GPG_OFS_PIN_VALUE, 8'h0e, 4'h1);
      xfer(1'b1, GPG_OFS_OUTPUT_LATCH, 8'h1f, 4'h0);
      rdchk("lat", GPG_OFS_OUTPUT_LATCH, 8'h0e);
      wt;
      chk("out", 8'h04, {3'h0, pad_out & pad_oe});
      xfer(1'b0, 12'h010, 8'h00, 4'hf);
      chk("slverr", 8'h01, {7'h0, err});
      @(posedge clk);
      ext <= 6'h08;
      wt;
      chk("master_clear_input", 8'h01, {7'h0, mcr});
      @(posedge clk);
      ext <= 6'h28;
      wt;
      chk("master_clear_input", 8'h00, {7'h0, mcr});
      rdchk("dir", GPG_OFS_DIRECTION, GPG_DIR_RESET);
      rdchk("lat", GPG_OFS_OUTPUT_LATCH, 8'h0e);
      for (int i = 0; i < GPG_IO_PINS; i++) begin
         @(posedge clk);
         p_en <= 5'h1 << i;
         p_fo <= 5'h1 << i;
         p_do <= 5'h1 << i;
         wt;
         chk("poe", 8'h1 << i, {3'h0, pad_oe});
         chk("pout", 8'h1 << i, {3'h0, pad_out & pad_oe});
      end
      xfer(1'b1, GPG_OFS_DIRECTION, 8'h00, 4'h1);
      @(posedge clk);
      p_en <= 5'h1f;
      p_fo <= 5'h00;
      wt;
      chk("poe", 8'h00, {3'h0, pad_oe});
      rdchk("dir", GPG_OFS_DIRECTION, 8'h00);
      @(posedge clk);
      p_en <= 5'h00;
      xfer(1'b1, GPG_OFS_CONFIG, 8'h00, 4'h1);
      wt;
      chk("oe", 8'h1f, {3'h0, pad_oe});
      rdchk("pin", GPG_OFS_PIN_VALUE, 8'h2e);
      @(posedge clk);
      ext <= 6'h08;
      wt;
      chk("master_clear_input", 8'h00, {7'h0, mcr});
      rdchk("pin", GPG_OFS_PIN_VALUE, 8'h0e);
      give_verdict;
   end
endmodule : tb_six_pin_gpio_port_with_reset_pin
